// ===== logic/daq_scan_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "daq_scan_defs.vh"

module daq_scan_sequencer #(
  parameter BLINK_CYCLES = `BLINK_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // software-paced conversion
  input wire convRequest,
  input wire [2:0] convChannel,
  input wire convDiff,
  input wire [1:0] convRange,
  output reg convDone,
  output reg [15:0] convData,
  // converter
  output reg adcStart,
  output reg [2:0] adcChannel,
  output reg adcDiff,
  output reg [1:0] adcRange,
  input wire adcDone,
  input wire [15:0] adcData,
  // scan control
  input wire scanStartCmd,
  input wire scanStopCmd,
  input wire startFromTrigger,
  input wire useExternalClock,
  input wire [31:0] samplePeriod,
  input wire [2:0] queueLast,
  output reg scanRunning,
  output reg scanArmed,
  output reg sampleOverrun,
  // queue write
  input wire queueWrite,
  input wire [2:0] queueAddr,
  input wire [5:0] queueEntry,
  // fifo drain
  input wire fifoReadReq,
  output wire [15:0] fifoReadData,
  output wire fifoReadValid,
  output reg [10:0] fifoLevel,
  output reg blockReady,
  // clock pins
  input wire extSampleClockIn,
  output reg scanClockOut,
  // trigger
  input wire externalStartLine,
  input wire trigConfigWrite,
  input wire trigLevelMode,
  input wire trigActiveLow,
  // event counter
  input wire pulseTallyInput,
  input wire tallyClear,
  output reg [31:0] tallyCount,
  // digital lines
  input wire [7:0] dioIn,
  output reg [7:0] dioOut,
  output reg [7:0] dioOe,
  input wire dioDirWrite,
  input wire [7:0] dioDirData,
  input wire dioOutWrite,
  input wire [7:0] dioOutData,
  output reg [7:0] dioRead,
  // analog outputs
  input wire dacLoad,
  input wire [15:0] dacZeroData,
  input wire [15:0] dacOneData,
  output reg [15:0] dacChannelZero,
  output reg [15:0] dacChannelOne,
  // indicator inputs
  input wire hostConnected,
  input wire cmdReceived,
  input wire powerGood,
  input wire linkUp,
  input wire netActivity,
  input wire linkSpeed100,
  // indicators
  output reg activityLed,
  output reg powerLed,
  output reg linkLed,
  output reg speedLed
);

  localparam S_IDLE = 3'h0;
  localparam S_ARMED = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_CONV = 3'h3;
  localparam S_SOFT = 3'h4;
  localparam [31:0] MIN_PERIOD = `MIN_PERIOD;

  function rose;
    input now;
    input prev;
    begin
      rose = now & ~prev;
    end
  endfunction

  reg rstSync1;
  reg rstSync2;
  wire rstn;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rstn = rstSync2;

  // 80 MHz timebase as 4 ticks in every 5 system cycles
  reg [2:0] tbPhase;
  reg tbTick;
  reg [31:0] periodCount;
  reg intTick;
  wire [31:0] effPeriod;
  // phase sum kept one bit wider so the step never wraps unseen
  wire [3:0] tbSum;
  wire [3:0] tbWrap;

  assign tbSum = {1'b0, tbPhase} + {1'b0, `TB_STEP};
  assign tbWrap = tbSum - {1'b0, `TB_MODULO};
  // period clamped so the internal clock never exceeds the rated throughput
  assign effPeriod = (samplePeriod < MIN_PERIOD) ? MIN_PERIOD :
                     samplePeriod;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tbPhase <= 3'h0;
      tbTick <= 1'b0;
      periodCount <= 32'h00000000;
      intTick <= 1'b0;
    end else begin
      if (tbSum >= {1'b0, `TB_MODULO}) begin
        tbPhase <= tbWrap[2:0];
        tbTick <= 1'b1;
      end else begin
        tbPhase <= tbSum[2:0];
        tbTick <= 1'b0;
      end
      intTick <= 1'b0;
      if (!scanRunning) begin
        periodCount <= 32'h00000000;
      end else if (tbTick) begin
        if (periodCount >= effPeriod - 32'h00000001) begin
          periodCount <= 32'h00000000;
          intTick <= 1'b1;
        end else begin
          periodCount <= periodCount + 32'h00000001;
        end
      end
    end
  end

  // pin edge detection and trigger configuration
  reg extClkPrev;
  reg trigPrev;
  reg tallyPrev;
  reg trigMode;
  reg trigPol;
  wire extTick;
  wire sampleTick;
  wire trigHit;

  assign extTick = rose(extSampleClockIn, extClkPrev);
  assign sampleTick = useExternalClock ? extTick : intTick;
  assign trigHit = (trigMode == `EXTERNAL_START_LINE_LEVEL_MODE) ?
    (externalStartLine ^ trigPol) :
    (trigPol ? rose(trigPrev, externalStartLine) :
               rose(externalStartLine, trigPrev));

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extClkPrev <= 1'b0;
      trigPrev <= 1'b0;
      tallyPrev <= 1'b0;
      trigMode <= `EXTERNAL_START_LINE_EDGE_MODE;
      trigPol <= `EXTERNAL_START_LINE_POL_RISE_HIGH;
      scanClockOut <= 1'b0;
      tallyCount <= 32'h00000000;
    end else begin
      extClkPrev <= extSampleClockIn;
      trigPrev <= externalStartLine;
      tallyPrev <= pulseTallyInput;
      if (trigConfigWrite) begin
        trigMode <= trigLevelMode;
        trigPol <= trigActiveLow;
      end
      scanClockOut <= !useExternalClock && intTick;
      // a clear in the same cycle as an edge keeps that edge
      if (tallyClear) begin
        tallyCount <= {31'h00000000, rose(pulseTallyInput, tallyPrev)};
      end else if (rose(pulseTallyInput, tallyPrev)) begin
        tallyCount <= tallyCount + 32'h00000001;
      end
    end
  end

  // channel-gain queue
  reg [2:0] qIndex;
  wire [5:0] qEntry;

  queue_memory queueMem (
    .clk(clk),
    .rstn(rstn),
    .writeEnable(queueWrite && !scanRunning),
    .writeAddr(queueAddr),
    .writeData(queueEntry),
    .readAddr(qIndex),
    .readData(qEntry)
  );

  // sample fifo
  reg pushValid;
  reg [15:0] pushData;
  wire fifoFull;
  wire [10:0] fifoCount;

  sample_fifo sampleFifo (
    .clk(clk),
    .rstn(rstn),
    .pushValid(pushValid),
    .pushData(pushData),
    .full(fifoFull),
    .popReq(fifoReadReq),
    .popData(fifoReadData),
    .popValid(fifoReadValid),
    .empty(),
    .count(fifoCount)
  );

  // scan engine
  reg [2:0] state;
  reg stopPending;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      stopPending <= 1'b0;
      qIndex <= 3'h0;
      scanRunning <= 1'b0;
      scanArmed <= 1'b0;
      sampleOverrun <= 1'b0;
      adcStart <= 1'b0;
      adcChannel <= 3'h0;
      adcDiff <= 1'b0;
      adcRange <= `RANGE_TEN_VOLT;
      convDone <= 1'b0;
      convData <= 16'h0000;
      pushValid <= 1'b0;
      pushData <= 16'h0000;
      fifoLevel <= 11'h000;
      blockReady <= 1'b0;
    end else begin
      adcStart <= 1'b0;
      convDone <= 1'b0;
      pushValid <= 1'b0;
      fifoLevel <= fifoCount;
      blockReady <= (fifoCount >= `BLOCK_WORDS);
      if (scanStopCmd && (scanRunning || scanArmed)) begin
        stopPending <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          stopPending <= 1'b0;
          qIndex <= 3'h0;
          if (scanStartCmd) begin
            sampleOverrun <= 1'b0;
            if (startFromTrigger) begin
              state <= S_ARMED;
              scanArmed <= 1'b1;
            end else begin
              state <= S_WAIT;
              scanRunning <= 1'b1;
            end
          end else if (convRequest) begin
            adcChannel <= convChannel;
            adcDiff <= convDiff;
            adcRange <= convRange;
            adcStart <= 1'b1;
            state <= S_SOFT;
          end
        end
        S_SOFT: begin
          if (adcDone) begin
            convData <= adcData;
            convDone <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_ARMED: begin
          if (scanStopCmd || stopPending) begin
            scanArmed <= 1'b0;
            state <= S_IDLE;
          end else if (trigHit) begin
            scanArmed <= 1'b0;
            scanRunning <= 1'b1;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (sampleTick) begin
            if (stopPending) begin
              scanRunning <= 1'b0;
              state <= S_IDLE;
            end else begin
              adcChannel <= qEntry[`ENTRY_CH_MSB:`ENTRY_CH_LSB];
              adcRange <= qEntry[`ENTRY_RANGE_MSB:`ENTRY_RANGE_LSB];
              adcDiff <= qEntry[`ENTRY_BALANCED_PAIR_MODE_BIT];
              adcStart <= 1'b1;
              state <= S_CONV;
            end
          end
        end
        S_CONV: begin
          // a tick during a conversion cannot be honoured; flag it
          if (sampleTick) begin
            sampleOverrun <= 1'b1;
          end
          if (adcDone) begin
            pushData <= adcData;
            pushValid <= 1'b1;
            if (fifoFull) begin
              sampleOverrun <= 1'b1;
            end
            qIndex <= (qIndex >= queueLast) ? 3'h0 :
                      qIndex + 3'h1;
            state <= S_WAIT;
          end
        end
        default: begin
          state <= S_IDLE;
          scanRunning <= 1'b0;
          scanArmed <= 1'b0;
        end
      endcase
    end
  end

  // digital lines, analog outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dioOe <= `DIO_DIR_RESET;
      dioOut <= `DIO_OUT_RESET;
      dioRead <= 8'h00;
      dacChannelZero <= 16'h0000;
      dacChannelOne <= 16'h0000;
    end else begin
      if (dioDirWrite) begin
        dioOe <= dioDirData;
      end
      if (dioOutWrite) begin
        dioOut <= dioOutData;
      end
      // output lines read back their driven value
      dioRead <= (dioIn & ~dioOe) | (dioOut & dioOe);
      if (dacLoad) begin
        dacChannelZero <= dacZeroData;
        dacChannelOne <= dacOneData;
      end
    end
  end

  // activity and link indicators share one blink timebase
  reg [31:0] blinkCount;
  reg blinkPhase;
  reg [1:0] actHold;
  reg [1:0] netHold;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blinkCount <= 32'h00000000;
      blinkPhase <= 1'b0;
      actHold <= 2'h0;
      netHold <= 2'h0;
      activityLed <= 1'b0;
      powerLed <= 1'b0;
      linkLed <= 1'b0;
      speedLed <= 1'b0;
    end else begin
      if (blinkCount >= BLINK_CYCLES - 1) begin
        blinkCount <= 32'h00000000;
        blinkPhase <= ~blinkPhase;
        // a command keeps blinking for one full on/off pair
        actHold <= cmdReceived ? 2'h2 :
                   (actHold != 2'h0) ? actHold - 2'h1 : 2'h0;
        // like a command, activity holds for one full on/off pair
        netHold <= netActivity ? 2'h2 :
                   (netHold != 2'h0) ? netHold - 2'h1 : 2'h0;
      end else begin
        blinkCount <= blinkCount + 32'h00000001;
        if (cmdReceived) begin
          actHold <= 2'h2;
        end
        if (netActivity) begin
          netHold <= 2'h2;
        end
      end
      activityLed <= hostConnected &&
        !((scanRunning || actHold != 2'h0) && blinkPhase);
      powerLed <= powerGood;
      linkLed <= linkUp &&
        !((netHold != 2'h0) && blinkPhase);
      speedLed <= linkUp && linkSpeed100;
    end
  end

endmodule
`default_nettype wire

// ===== inc/daq_scan_defs.vh
`ifndef DAQ_SCAN_DEFS_VH
`define DAQ_SCAN_DEFS_VH

// clocking and timebase
`define SYS_CLOCK_HZ 100000000
`define TIMEBASE_HZ 80000000
`define TB_STEP 3'h4
`define TB_MODULO 3'h5
`define MAX_SCAN_RATE_SPS 250000
`define MIN_PERIOD (`TIMEBASE_HZ / `MAX_SCAN_RATE_SPS)

// channel-gain queue
`define QUEUE_DEPTH 8
`define QUEUE_AW 3
`define ENTRY_W 6
`define ENTRY_CH_LSB 0
`define ENTRY_CH_MSB 2
`define ENTRY_RANGE_LSB 3
`define ENTRY_RANGE_MSB 4
`define ENTRY_BALANCED_PAIR_MODE_BIT 5

// input ranges
`define RANGE_TEN_VOLT 2'h0
`define RANGE_FIVE_VOLT 2'h1
`define RANGE_TWO_VOLT 2'h2
`define RANGE_ONE_VOLT 2'h3

// sample fifo
`define FIFO_AW 10
`define FIFO_DEPTH 1024
`define SAMPLE_W 16
`define BLOCK_WORDS 11'h100

// trigger configuration encodings, edge mode and rising/high polarity at reset
`define EXTERNAL_START_LINE_EDGE_MODE 1'b0
`define EXTERNAL_START_LINE_LEVEL_MODE 1'b1
`define EXTERNAL_START_LINE_POL_RISE_HIGH 1'b0
`define EXTERNAL_START_LINE_POL_FALL_LOW 1'b1

// digital lines reset values
`define DIO_DIR_RESET 8'h00
`define DIO_OUT_RESET 8'h00

// indicator blink half period
`define BLINK_HALF_MS 50
`define BLINK_CYCLES (`BLINK_HALF_MS * (`SYS_CLOCK_HZ / 1000))

`endif

// ===== logic/queue_memory.v
`timescale 1ns/1ps
`default_nettype none
`include "daq_scan_defs.vh"

module queue_memory (
  // clock and reset
  input wire clk,
  input wire rstn,
  // write side
  input wire writeEnable,
  input wire [`QUEUE_AW-1:0] writeAddr,
  input wire [`ENTRY_W-1:0] writeData,
  // read side
  input wire [`QUEUE_AW-1:0] readAddr,
  output reg [`ENTRY_W-1:0] readData
);

  reg [`ENTRY_W-1:0] mem [0:`QUEUE_DEPTH-1];

  // any channel order and duplicates are just plain entries
  always @(posedge clk) begin
    if (writeEnable) begin
      mem[writeAddr] <= writeData;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readData <= {`ENTRY_W{1'b0}};
    end else begin
      readData <= mem[readAddr];
    end
  end

endmodule
`default_nettype wire

// ===== logic/sample_fifo.v
`timescale 1ns/1ps
`default_nettype none
`include "daq_scan_defs.vh"

module sample_fifo (
  // clock and reset
  input wire clk,
  input wire rstn,
  // fill side
  input wire pushValid,
  input wire [`SAMPLE_W-1:0] pushData,
  output wire full,
  // drain side
  input wire popReq,
  output reg [`SAMPLE_W-1:0] popData,
  output reg popValid,
  output wire empty,
  output reg [`FIFO_AW:0] count
);

  reg [`SAMPLE_W-1:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wrPtr;
  reg [`FIFO_AW-1:0] rdPtr;
  wire doPush;
  wire doPop;

  assign full = (count == `FIFO_DEPTH);
  assign empty = (count == {(`FIFO_AW+1){1'b0}});
  assign doPush = pushValid && !full;
  assign doPop = popReq && !empty;

  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= {`FIFO_AW{1'b0}};
      rdPtr <= {`FIFO_AW{1'b0}};
      count <= {(`FIFO_AW+1){1'b0}};
      popData <= {`SAMPLE_W{1'b0}};
      popValid <= 1'b0;
    end else begin
      popValid <= doPop;
      if (doPop) begin
        popData <= mem[rdPtr];
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/daq_scan_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module daq_scan_sequencer_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched inputs
  input wire logic adcDone,
  input wire logic [15:0] adcData,
  input wire logic dacLoad,
  input wire logic [15:0] dacZeroData,
  input wire logic [15:0] dacOneData,
  input wire logic dioDirWrite,
  input wire logic [7:0] dioDirData,
  input wire logic tallyClear,
  input wire logic useExternalClock,
  input wire logic hostConnected,
  input wire logic powerGood,
  input wire logic linkUp,
  input wire logic linkSpeed100,
  // watched outputs
  input wire logic convDone,
  input wire logic [15:0] convData,
  input wire logic [15:0] dacChannelZero,
  input wire logic [15:0] dacChannelOne,
  input wire logic [7:0] dioOe,
  input wire logic [31:0] tallyCount,
  input wire logic scanClockOut,
  input wire logic scanRunning,
  input wire logic powerLed,
  input wire logic linkLed,
  input wire logic speedLed,
  input wire logic activityLed
);
  // internal reset lags resetn by two flops, so hold checks off a while
  logic [2:0] age;
  wire live;
  assign live = (age == 3'h7);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) age <= 3'h0;
    else if (!live) age <= age + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_conv_result: assert property (
    live && convDone |-> $past(adcDone) && convData == $past(adcData))
    else $error("conversion result not from last converter answer");
  a_dac_together: assert property (live && dacLoad |=>
    dacChannelZero == $past(dacZeroData) && dacChannelOne == $past(dacOneData))
    else $error("analog outputs not loaded together");
  a_dio_direction: assert property (
    live && dioDirWrite |=> dioOe == $past(dioDirData))
    else $error("line direction not taken");
  a_tally_step: assert property (live && !tallyClear |=>
    tallyCount == $past(tallyCount) || tallyCount == $past(tallyCount) + 1)
    else $error("event count moved by more than one");
  a_power_led: assert property (
    live |-> powerLed == $past(powerGood))
    else $error("power indicator wrong");
  a_speed_led: assert property (
    live |-> speedLed == ($past(linkUp) && $past(linkSpeed100)))
    else $error("speed indicator wrong");
  a_link_dark: assert property (
    live && !$past(linkUp) |-> !linkLed)
    else $error("link indicator lit without link");
  a_activity_dark: assert property (
    live && !$past(hostConnected) |-> !activityLed)
    else $error("activity indicator lit without host");
  a_clock_quiet: assert property (
    live && useExternalClock && $past(useExternalClock) |-> !scanClockOut)
    else $error("scan clock driven while external clock paces");
  c_conversion: cover property (convDone);
  c_scan: cover property ($rose(scanRunning));
  c_dac: cover property (dacLoad);
endmodule
`default_nettype wire

// ===== tb/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // converter request
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  input wire logic adcDiff,
  input wire logic [1:0] adcRange,
  input wire logic slowAnswer,
  // converter answer
  output logic adcDone,
  output logic [15:0] adcData
);
  logic [7:0] busyCount;
  logic [15:0] held;
  // inverse outside the answer cycle, so stale data never passes
  assign adcData = adcDone ? held : ~held;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busyCount <= 8'h0;
      adcDone <= 1'b0;
      held <= 16'h0;
    end else begin
      adcDone <= 1'b0;
      if (adcStart) begin
        busyCount <= slowAnswer ? 8'h3c : 8'h03;
        held <= {adcChannel, adcRange, adcDiff, 10'h2a5};
      end else if (busyCount == 8'h1) begin
        busyCount <= 8'h0;
        adcDone <= 1'b1;
      end else if (busyCount != 8'h0) begin
        busyCount <= busyCount - 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/daq_scan_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module daq_scan_sequencer_tb_top;
  logic clk = 0, resetn = 0, slowAnswer = 0, adcDone, convDone, convDiff = 0;
  logic convRequest = 0, scanStartCmd = 0, scanStopCmd = 0, adcStart, adcDiff;
  logic startFromTrigger = 0, useExternalClock = 0, queueWrite = 0;
  logic fifoReadReq = 0, extSampleClockIn = 0, externalStartLine = 0;
  logic trigConfigWrite = 0, trigLevelMode = 0, trigActiveLow = 0;
  logic pulseTallyInput = 0, tallyClear = 0, dioDirWrite = 0, dioOutWrite = 0;
  logic dacLoad = 0, hostConnected = 0, cmdReceived = 0, powerGood = 0;
  logic linkUp = 0, netActivity = 0, linkSpeed100 = 0;
  logic [2:0] convChannel = 0, queueLast = 0, queueAddr = 0, adcChannel;
  logic [1:0] convRange = 0, adcRange;
  logic [5:0] queueEntry = 0;
  logic [31:0] samplePeriod = 0, tallyCount;
  logic [7:0] dioIn = 0, dioDirData = 0, dioOutData = 0, dioOut, dioOe, dioRead;
  logic [15:0] dacZeroData = 0, dacOneData = 0, adcData, convData, fifoReadData;
  logic [15:0] dacChannelZero, dacChannelOne;
  logic [10:0] fifoLevel;
  logic scanRunning, scanArmed, sampleOverrun, fifoReadValid, blockReady;
  logic scanClockOut, activityLed, powerLed, linkLed, speedLed;
  int nMismatch = 0, nTests = 0, nStarts = 0, nClk = 0, cycNow = 0;
  int lastPulse = 0, gap = 0, k, n, s0;
  // dac zero, dac one, direction, out, in, expected read
  localparam logic [63:0] rows [0:2] = '{64'h1234_fedc_f0a5_3cac,
    64'h8000_7fff_0f5a_c3ca, 64'hffff_0001_00ff_8181};
  // all four ranges, a pair, and one channel twice
  localparam logic [5:0] q [0:3] = '{6'h0d, 6'h01, 6'h3b, 6'h15};
  daq_scan_sequencer #(.BLINK_CYCLES(8)) daq_scan_sequencer_inst (.*);
  adc_model adc_model_inst (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycNow++;
    if (adcStart === 1'b1) nStarts++;
    if (scanClockOut === 1'b1) begin
      gap = cycNow - lastPulse;
      lastPulse = cycNow;
      nClk++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic pop(input logic [15:0] exp);
    fifoReadReq = 1'b1;
    @(negedge clk);
    fifoReadReq = 1'b0;
    check(fifoReadValid, 1);
    check(fifoReadData, exp);
    @(negedge clk);
  endtask
  task automatic tick();
    extSampleClockIn = 1'b1;
    cyc(2);
    extSampleClockIn = 1'b0;
    cyc(8);
  endtask
  initial begin
    #400us;
    nMismatch++;
    report_and_stop();
  end
  initial begin
    cyc(4);
    resetn = 1'b1;
    cyc(4);
    check(tallyCount, 0);
    check(dioOe, 0);
    foreach (rows[i]) begin
      {dacZeroData, dacOneData, dioDirData, dioOutData, dioIn} = rows[i][63:8];
      dacLoad = 1'b1;
      dioDirWrite = 1'b1;
      dioOutWrite = 1'b1;
      @(negedge clk);
      dacLoad = 1'b0;
      dioDirWrite = 1'b0;
      dioOutWrite = 1'b0;
      check(dacChannelZero, rows[i][63:48]);
      check(dacChannelOne, rows[i][47:32]);
      check(dioOe, rows[i][31:24]);
      check(dioOut, rows[i][23:16]);
      cyc(3);
      check(dioRead, rows[i][7:0]);
    end
    {powerGood, linkUp, linkSpeed100, hostConnected} = 4'hf;
    cyc(40);
    check({powerLed, speedLed, linkLed, activityLed}, 4'hf);
    cmdReceived = 1'b1;
    netActivity = 1'b1;
    @(negedge clk);
    cmdReceived = 1'b0;
    netActivity = 1'b0;
    for (k = 0; k < 40 && activityLed !== 1'b0; k++) @(negedge clk);
    check(activityLed, 0);
    for (k = 0; k < 40 && linkLed !== 1'b0; k++) @(negedge clk);
    check(linkLed, 0);
    linkSpeed100 = 1'b0;
    powerGood = 1'b0;
    cyc(2);
    check({powerLed, speedLed}, 0);
    powerGood = 1'b1;
    tallyClear = 1'b1;
    @(negedge clk);
    tallyClear = 1'b0;
    repeat (5) begin
      pulseTallyInput = 1'b1;
      cyc(2);
      pulseTallyInput = 1'b0;
      cyc(2);
    end
    cyc(3);
    check(tallyCount, 5);
    slowAnswer = 1'b1;
    s0 = nStarts;
    {convChannel, convRange, convRequest} = {3'h5, 2'h1, 1'b1};
    @(negedge clk);
    convRequest = 1'b0;
    for (k = 0; k < 200 && convDone !== 1'b1; k++) @(negedge clk);
    check(convData, {3'h5, 2'h1, 1'b0, 10'h2a5});
    cyc(80);
    check(nStarts - s0, 1);
    slowAnswer = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {queueAddr, queueEntry, queueWrite} = {i[2:0], q[i], 1'b1};
      @(negedge clk);
      queueWrite = 1'b0;
      @(negedge clk);
    end
    queueLast = 3'h3;
    samplePeriod = 32'h1;
    scanStartCmd = 1'b1;
    @(negedge clk);
    scanStartCmd = 1'b0;
    for (k = 0; k < 6000 && fifoLevel < 11'd9; k++) @(negedge clk);
    check(gap >= 399 && gap <= 401, 1);
    scanStopCmd = 1'b1;
    @(negedge clk);
    scanStopCmd = 1'b0;
    for (k = 0; k < 600 && scanRunning !== 1'b0; k++) @(negedge clk);
    cyc(4);
    check(fifoLevel >= 11'd9, 1);
    n = fifoLevel;
    for (int i = 0; i < n; i++)
      pop({q[i % 4][2:0], q[i % 4][4:3], q[i % 4][5], 10'h2a5});
    cyc(3);
    check(fifoLevel, 0);
    {startFromTrigger, useExternalClock, scanStartCmd} = 3'h7;
    @(negedge clk);
    scanStartCmd = 1'b0;
    cyc(3);
    check({scanArmed, scanRunning}, 2'h2);
    externalStartLine = 1'b1;
    cyc(4);
    check(scanRunning, 1);
    s0 = nClk;
    repeat (3) tick();
    check(nClk - s0, 0);
    scanStopCmd = 1'b1;
    @(negedge clk);
    scanStopCmd = 1'b0;
    tick();
    check(scanRunning, 0);
    for (int i = 0; i < 3; i++)
      pop({q[i][2:0], q[i][4:3], q[i][5], 10'h2a5});
    {trigLevelMode, trigActiveLow, trigConfigWrite} = 3'h7;
    @(negedge clk);
    trigConfigWrite = 1'b0;
    scanStartCmd = 1'b1;
    @(negedge clk);
    scanStartCmd = 1'b0;
    cyc(3);
    check({scanArmed, scanRunning}, 2'h2);
    externalStartLine = 1'b0;
    cyc(4);
    check(scanRunning, 1);
    repeat (256) tick();
    check(blockReady, 1);
    check(sampleOverrun, 0);
    slowAnswer = 1'b1;
    repeat (2) tick();
    check(sampleOverrun, 1);
    scanStopCmd = 1'b1;
    @(negedge clk);
    scanStopCmd = 1'b0;
    cyc(80);
    slowAnswer = 1'b0;
    tick();
    check(scanRunning, 0);
    {trigLevelMode, trigActiveLow, trigConfigWrite} = 3'h3;
    @(negedge clk);
    trigConfigWrite = 1'b0;
    scanStartCmd = 1'b1;
    @(negedge clk);
    scanStartCmd = 1'b0;
    externalStartLine = 1'b1;
    cyc(3);
    check({scanArmed, scanRunning, sampleOverrun}, 3'h4);
    externalStartLine = 1'b0;
    cyc(4);
    check(scanRunning, 1);
    report_and_stop();
  end
endmodule
bind daq_scan_sequencer daq_scan_sequencer_checker
  daq_scan_sequencer_checker_inst (.*);
`default_nettype wire
